/* File: hdl/charger_pkg.sv */
// shared constants and types of the charger control block
package charger_pkg;
  // ==========================================================
  // register map: index, byte address is index times four
  localparam int ADDR_W = 6;
  localparam logic [3:0] IDX_INPUT_LIMIT = 4'h0;
  localparam logic [3:0] IDX_POWER_ON_CONFIG = 4'h1;
  localparam logic [3:0] IDX_FAST_CURRENT = 4'h2;
  localparam logic [3:0] IDX_PRE_TERM_CURRENT = 4'h3;
  localparam logic [3:0] IDX_CHARGE_VOLTAGE = 4'h4;
  localparam logic [3:0] IDX_TERM_CONTROL = 4'h5;
  localparam logic [3:0] IDX_COMPENSATION = 4'h6;
  localparam logic [3:0] IDX_MISC_CONTROL = 4'h7;
  localparam logic [3:0] IDX_SYSTEM_STATUS = 4'h8;
  localparam logic [3:0] IDX_FAULT = 4'h9;
  localparam int NUM_WR_REGS = 8;
  // ==========================================================
  // reset values and writable bits of the control registers
  localparam logic [7:0] REG_RST [0:7] = '{8'h32, 8'h1B, 8'h60, 8'h11, 8'hB2, 8'h80, 8'h00, 8'h00};
  localparam logic [7:0] REG_WMASK [0:7] = '{8'h7F, 8'h3F, 8'hFC, 8'hFF, 8'hFF, 8'h80, 8'hFC, 8'h20};
  // ==========================================================
  // field positions
  localparam int IIN_LSB = 0;
  localparam int VIN_LSB = 3;
  localparam int BOOST_LIM_BIT = 0;
  localparam int SYSMIN_LSB = 1;
  localparam int CHG_CFG_LSB = 4;
  localparam int FAST_LSB = 2;
  localparam int TERM_LSB = 0;
  localparam int PRE_LSB = 4;
  localparam int RECHG_SEL_BIT = 0;
  localparam int LOWBAT_SEL_BIT = 1;
  localparam int VREG_LSB = 2;
  localparam int TERM_EN_BIT = 7;
  localparam int CLAMP_LSB = 2;
  localparam int RCOMP_LSB = 5;
  localparam int SWITCH_OFF_BIT = 5;
  // ==========================================================
  // field codes
  localparam logic [1:0] CFG_CHARGE = 2'b01;
  localparam logic [1:0] CFG_BOOST = 2'b10;
  localparam logic [1:0] SRC_BOOST = 2'b11;
  localparam logic [1:0] SRC_NONE = 2'b00;
  localparam logic [1:0] PH_DISABLED = 2'b00;
  localparam logic [1:0] PH_PRE = 2'b01;
  localparam logic [1:0] PH_FAST = 2'b10;
  localparam logic [1:0] PH_DONE = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int INT_PULSE_US = 256;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  localparam int BOOST_DELAY_MS = 220;
  localparam int BOOST_DELAY_CYC = BOOST_DELAY_MS * 1000 * CLK_MHZ;
  localparam int BLINK_HZ = 1;
  localparam int BLINK_HALF_CYC = CLK_MHZ * 1000000 / (2 * BLINK_HZ);
  localparam int SECOND_CYC = CLK_MHZ * 1000000;
  localparam int SAFETY_HOURS = 8;
  localparam int SAFETY_SEC = SAFETY_HOURS * 3600;
  typedef enum logic [2:0] {CH_IDLE, CH_PRE, CH_FAST, CH_DONE, CH_SUSPEND} charge_state_e;
  typedef enum logic [1:0] {BO_OFF, BO_WAIT, BO_ON} boost_state_e;
endpackage

/* File: hdl/charger_state_control.sv */
// control logic of a single-cell charger with register slave
`timescale 1ns/1ns
module charger_state_control #(
  parameter int INT_PULSE = charger_pkg::INT_PULSE_CYC,
  parameter int BOOST_DELAY = charger_pkg::BOOST_DELAY_CYC,
  parameter int BLINK_HALF = charger_pkg::BLINK_HALF_CYC,
  parameter int SECOND = charger_pkg::SECOND_CYC,
  parameter int SAFETY_LIMIT = charger_pkg::SAFETY_SEC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // axi4-lite write
  input wire logic [charger_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [charger_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins and comparators, asynchronous
  input wire logic reversePowerPin,
  input wire logic chargeEnableN,
  input wire logic [1:0] batAboveLowBattery,
  input wire logic vbusBelowSleep,
  input wire logic batAbove2V,
  input wire logic batAbove3V,
  input wire logic [1:0] batBelowRecharge,
  input wire logic chargeBelowTerm,
  input wire logic inCurOverLimit,
  input wire logic inVoltUnderLimit,
  input wire logic sysBelowBat,
  input wire logic sysAtMinimum,
  input wire logic thermalReg,
  input wire logic converterRunning,
  input wire logic boostOverVolt,
  input wire logic boostOverCur,
  input wire logic [1:0] thermColdA,
  input wire logic [1:0] thermHotB,
  input wire logic [1:0] thermCutoff,
  // controls to the power stage
  output logic boostRun,
  output logic boostCurHigh,
  output logic chargeRun,
  output logic fixedLowCurrent,
  output logic [5:0] chargeCurCode,
  output logic reduceChargeCur,
  output logic batterySwitchOn,
  output logic [2:0] sysMinCode,
  output logic [2:0] inCurLimitCode,
  output logic [3:0] inVoltLimitCode,
  output logic [7:0] batRegTarget,
  // status pin, open drain, and interrupt
  output logic statusPinOut,
  output logic statusPinOe,
  output logic interruptOut
);
  import charger_pkg::*;

  initial begin
    if (INT_PULSE < 1 || BOOST_DELAY < 1 || BLINK_HALF < 1 || SECOND < 1 || SAFETY_LIMIT < 1) begin
      $error("timing parameters must be at least one");
    end
  end

  // ==========================================================
  // input synchroniser
  localparam int NCMP = 24;
  logic [NCMP-1:0] rawCmp;
  logic [NCMP-1:0] cmpMetaFf;
  logic [NCMP-1:0] cmpFf;
  assign rawCmp = {reversePowerPin, chargeEnableN, batAboveLowBattery, vbusBelowSleep, batAbove2V,
                   batAbove3V, batBelowRecharge, chargeBelowTerm, inCurOverLimit, inVoltUnderLimit,
                   sysBelowBat, sysAtMinimum, thermalReg, converterRunning, boostOverVolt,
                   boostOverCur, thermColdA, thermHotB, thermCutoff};
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmpMetaFf <= '0;
      cmpFf <= '0;
    end else begin
      cmpMetaFf <= rawCmp;
      cmpFf <= cmpMetaFf;
    end
  end

  logic sOtg, sCeN, sVbusSleep, sAbove2, sAbove3, sBelowTerm, sCurOver, sVoltUnder;
  logic sSysBelow, sSysMin, sThermal, sConv, sBoostOv, sBoostOc;
  logic [1:0] sLowBat, sRechg, sCold, sHot, sCut;
  assign {sOtg, sCeN, sLowBat, sVbusSleep, sAbove2, sAbove3, sRechg, sBelowTerm, sCurOver,
          sVoltUnder, sSysBelow, sSysMin, sThermal, sConv, sBoostOv, sBoostOc, sCold, sHot,
          sCut} = cmpFf;

  // ==========================================================
  // control registers and bus
  logic [7:0] ctrlFf [0:NUM_WR_REGS-1];
  logic [ADDR_W-1:0] awAddrFf;
  logic [7:0] wByteFf;
  logic wLane0Ff;
  logic doWrite;
  logic [3:0] wIdx;
  logic [3:0] rIdx;
  logic [1:0] statusSrc;
  logic [1:0] phaseCode;
  logic dpmActive;
  logic boostFaultFf;
  logic [2:0] thermFaultFf;
  logic faultReadClr;
  logic [7:0] statusByte;
  logic [7:0] faultByte;
  logic [7:0] readByte;
  logic readMapped;

  assign doWrite = !awready && !wready && !bvalid;
  assign wIdx = awAddrFf[ADDR_W-1:2];
  assign rIdx = araddr[ADDR_W-1:2];
  assign faultReadClr = arvalid && arready && rIdx == IDX_FAULT;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      awAddrFf <= '0;
      wByteFf <= 8'h00;
      wLane0Ff <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awAddrFf <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wByteFf <= wdata[7:0];
        wLane0Ff <= wstrb[0];
        wready <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp <= (wIdx < 4'(NUM_WR_REGS)) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // default currents and voltage from reset values
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrlFf <= REG_RST;
    end else if (doWrite && wLane0Ff) begin
      for (int i = 0; i < NUM_WR_REGS; i++) begin
        if (wIdx == 4'(i)) begin
          ctrlFf[i] <= wByteFf & REG_WMASK[i];
        end
      end
    end
  end

  assign statusByte = {statusSrc, phaseCode, dpmActive, 2'b00, sSysMin};
  assign faultByte = {1'b0, boostFaultFf, 3'b000, thermFaultFf};

  always_comb begin
    readByte = 8'h00;
    readMapped = 1'b1;
    if (rIdx < 4'(NUM_WR_REGS)) begin
      readByte = ctrlFf[rIdx[2:0]];
    end else if (rIdx == IDX_SYSTEM_STATUS) begin
      readByte = statusByte;
    end else if (rIdx == IDX_FAULT) begin
      readByte = faultByte;
    end else begin
      readMapped = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, readByte};
        rresp <= readMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // field views
  logic [1:0] chgCfg;
  logic termEnable;
  logic switchForcedOff;
  logic lowBatOk;
  logic rechargeLow;
  assign chgCfg = ctrlFf[IDX_POWER_ON_CONFIG[2:0]][CHG_CFG_LSB +: 2];
  assign termEnable = ctrlFf[IDX_TERM_CONTROL[2:0]][TERM_EN_BIT];
  assign switchForcedOff = ctrlFf[IDX_MISC_CONTROL[2:0]][SWITCH_OFF_BIT];
  // threshold selection bits pick one of two comparators
  assign lowBatOk = sLowBat[ctrlFf[IDX_CHARGE_VOLTAGE[2:0]][LOWBAT_SEL_BIT]];
  assign rechargeLow = sRechg[ctrlFf[IDX_CHARGE_VOLTAGE[2:0]][RECHG_SEL_BIT]];

  // ==========================================================
  // boost mode
  boost_state_e boostStateFf;
  logic [31:0] boostCntFf;
  logic boostQualified;
  logic boostFaultEv;
  assign boostQualified = lowBatOk && sVbusSleep && sOtg && chgCfg == CFG_BOOST;
  assign boostFaultEv = boostStateFf == BO_ON && (sBoostOv || sBoostOc);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      boostStateFf <= BO_OFF;
      boostCntFf <= '0;
    end else begin
      case (boostStateFf)
        BO_OFF: begin
          boostCntFf <= '0;
          if (boostQualified) begin
            boostStateFf <= BO_WAIT;
          end
        end
        // hold off for the enable delay
        BO_WAIT: begin
          boostCntFf <= boostCntFf + 32'd1;
          if (!boostQualified) begin
            boostStateFf <= BO_OFF;
          end else if (boostCntFf >= 32'(BOOST_DELAY - 1)) begin
            boostStateFf <= BO_ON;
          end
        end
        BO_ON: begin
          if (!boostQualified || boostFaultEv) begin
            boostStateFf <= BO_OFF;
          end
        end
        default: boostStateFf <= BO_OFF;
      endcase
    end
  end

  assign statusSrc = (boostStateFf == BO_ON) ? SRC_BOOST : SRC_NONE;
  assign dpmActive = sCurOver || sVoltUnder;

  // ==========================================================
  // charge cycle
  charge_state_e chgStateFf;
  charge_state_e nxt_chgState;
  logic startOk;
  logic runOk;
  logic chargeAllowed;
  logic timerFaultFf;
  logic canStart;
  logic doneEv;
  logic thermFaultEv;
  logic [2:0] thermNow;

  assign startOk = !(|sCold) && !(|sHot);
  assign runOk = !(|sCold) && !(|sCut);
  assign chargeAllowed = chgCfg == CFG_CHARGE && !sCeN;
  assign canStart = sConv && chargeAllowed && startOk && !timerFaultFf && !switchForcedOff;
  // bit0 sensor a, bit1 sensor b, bit2 any sensor cold
  assign thermNow = {|sCold, sCold[1] | sHot[1] | sCut[1], sCold[0] | sHot[0] | sCut[0]};

  always_comb begin
    nxt_chgState = chgStateFf;
    case (chgStateFf)
      CH_IDLE: begin
        if (canStart) begin
          nxt_chgState = sAbove3 ? CH_FAST : CH_PRE;
        end
      end
      CH_PRE: begin
        if (sAbove3) begin
          nxt_chgState = CH_FAST;
        end
      end
      CH_FAST: begin
        if (termEnable && sBelowTerm && !rechargeLow && !dpmActive && !sThermal) begin
          nxt_chgState = CH_DONE;
        end
      end
      CH_DONE: begin
        if (rechargeLow && canStart) begin
          nxt_chgState = sAbove3 ? CH_FAST : CH_PRE;
        end
      end
      CH_SUSPEND: begin
        if (startOk) begin
          nxt_chgState = CH_IDLE;
        end
      end
      default: nxt_chgState = CH_IDLE;
    endcase
    if (chgStateFf == CH_PRE || chgStateFf == CH_FAST) begin
      if (!runOk) begin
        nxt_chgState = CH_SUSPEND;
      end
    end
    // boost and charging share the power stage, so charging waits until boost is fully off
    if (!chargeAllowed || !sConv || switchForcedOff || timerFaultFf || boostStateFf != BO_OFF) begin
      nxt_chgState = CH_IDLE;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      chgStateFf <= CH_IDLE;
    end else begin
      chgStateFf <= nxt_chgState;
    end
  end

  assign doneEv = chgStateFf == CH_FAST && nxt_chgState == CH_DONE;
  assign thermFaultEv = (chgStateFf == CH_PRE || chgStateFf == CH_FAST) && !runOk;

  always_comb begin
    case (chgStateFf)
      CH_PRE: phaseCode = PH_PRE;
      CH_FAST: phaseCode = PH_FAST;
      CH_DONE: phaseCode = PH_DONE;
      default: phaseCode = PH_DISABLED;
    endcase
  end

  // ==========================================================
  // safety timer, one-second ticks
  logic [31:0] secDivFf;
  logic [31:0] safetySecFf;
  logic halfPhaseFf;
  logic charging;
  assign charging = chgStateFf == CH_PRE || chgStateFf == CH_FAST;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      secDivFf <= '0;
      safetySecFf <= '0;
      halfPhaseFf <= 1'b0;
      timerFaultFf <= 1'b0;
    end else if (!chargeAllowed) begin
      // fault clears only when charging is disabled and re-enabled
      secDivFf <= '0;
      safetySecFf <= '0;
      timerFaultFf <= 1'b0;
    end else if (chgStateFf == CH_IDLE || chgStateFf == CH_DONE) begin
      secDivFf <= '0;
      safetySecFf <= '0;
    end else if (charging) begin
      if (secDivFf >= 32'(SECOND - 1)) begin
        secDivFf <= '0;
        halfPhaseFf <= !halfPhaseFf;
        // every other second counts while regulating
        if (!(dpmActive || sThermal) || halfPhaseFf) begin
          safetySecFf <= safetySecFf + 32'd1;
        end
      end else begin
        secDivFf <= secDivFf + 32'd1;
      end
      if (safetySecFf >= 32'(SAFETY_LIMIT)) begin
        timerFaultFf <= 1'b1;
      end
    end
  end

  // ==========================================================
  // fault register, cleared by a read, a new fault wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      boostFaultFf <= 1'b0;
      thermFaultFf <= 3'b000;
    end else begin
      if (boostFaultEv) begin
        boostFaultFf <= 1'b1;
      end else if (faultReadClr) begin
        boostFaultFf <= 1'b0;
      end
      if (thermFaultEv) begin
        thermFaultFf <= thermNow;
      end else if (faultReadClr) begin
        thermFaultFf <= 3'b000;
      end
    end
  end

  // ==========================================================
  // interrupt pulse
  logic [31:0] intCntFf;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      intCntFf <= '0;
      interruptOut <= 1'b0;
    end else if (intCntFf == 32'd0) begin
      // one fixed pulse per event; events during a pulse merge
      if (doneEv || boostFaultEv || thermFaultEv) begin
        intCntFf <= 32'(INT_PULSE - 1);
        interruptOut <= 1'b1;
      end else begin
        interruptOut <= 1'b0;
      end
    end else begin
      intCntFf <= intCntFf - 32'd1;
      interruptOut <= 1'b1;
    end
  end

  // ==========================================================
  // status pin, open drain: enable pulls low
  logic [31:0] blinkCntFf;
  logic blinkFf;
  logic faultShown;
  assign faultShown = chgStateFf == CH_SUSPEND || timerFaultFf;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      blinkCntFf <= '0;
      blinkFf <= 1'b0;
      statusPinOe <= 1'b0;
      statusPinOut <= 1'b0;
    end else begin
      if (blinkCntFf >= 32'(BLINK_HALF - 1)) begin
        blinkCntFf <= '0;
        blinkFf <= !blinkFf;
      end else begin
        blinkCntFf <= blinkCntFf + 32'd1;
      end
      // low charging, blink on fault, else released high
      statusPinOe <= faultShown ? blinkFf : charging;
      statusPinOut <= 1'b0;
    end
  end

  // ==========================================================
  // power stage controls
  logic [5:0] preCode;
  logic [8:0] compProd;
  logic [2:0] compAdd;
  logic [2:0] clampCode;
  assign preCode = {2'b00, ctrlFf[IDX_PRE_TERM_CURRENT[2:0]][PRE_LSB +: 4]};
  assign clampCode = ctrlFf[IDX_COMPENSATION[2:0]][CLAMP_LSB +: 3];
  assign compProd = chargeCurCode * ctrlFf[IDX_COMPENSATION[2:0]][RCOMP_LSB +: 3];
  assign compAdd = (compProd < {6'd0, clampCode}) ? compProd[2:0] : clampCode;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      boostRun <= 1'b0;
      boostCurHigh <= 1'b0;
      chargeRun <= 1'b0;
      fixedLowCurrent <= 1'b0;
      chargeCurCode <= 6'd0;
      reduceChargeCur <= 1'b0;
      batterySwitchOn <= 1'b0;
      sysMinCode <= 3'd0;
      inCurLimitCode <= 3'd0;
      inVoltLimitCode <= 4'd0;
      batRegTarget <= 8'd0;
    end else begin
      boostRun <= boostStateFf == BO_ON;
      boostCurHigh <= ctrlFf[IDX_POWER_ON_CONFIG[2:0]][BOOST_LIM_BIT];
      chargeRun <= charging;
      // fixed low current below lower threshold
      fixedLowCurrent <= chgStateFf == CH_PRE && !sAbove2;
      chargeCurCode <= (chgStateFf == CH_FAST) ? ctrlFf[IDX_FAST_CURRENT[2:0]][FAST_LSB +: 6] : preCode;
      // reduce while either limit is breached
      reduceChargeCur <= dpmActive;
      batterySwitchOn <= !switchForcedOff && (charging || sSysBelow);
      sysMinCode <= ctrlFf[IDX_POWER_ON_CONFIG[2:0]][SYSMIN_LSB +: 3];
      inCurLimitCode <= ctrlFf[IDX_INPUT_LIMIT[2:0]][IIN_LSB +: 3];
      inVoltLimitCode <= ctrlFf[IDX_INPUT_LIMIT[2:0]][VIN_LSB +: 4];
      batRegTarget <= {2'b00, ctrlFf[IDX_CHARGE_VOLTAGE[2:0]][VREG_LSB +: 6]} + {5'd0, compAdd};
    end
  end
endmodule

/* File: tb/charger_state_control_chk.sv */
// concurrent checks on the charger control ports
`timescale 1ns/1ns
module charger_state_control_chk #(
  parameter int INT_PULSE = 8
) (
  // clock and reset
  input wire logic clk_sys, reset,
  // watched pins
  input wire logic reversePowerPin, chargeEnableN, sysBelowBat, inCurOverLimit, inVoltUnderLimit,
  input wire logic [1:0] batAboveLowBattery,
  input wire logic boostOverVolt, boostOverCur,
  input wire logic boostRun, chargeRun, reduceChargeCur, batterySwitchOn, statusPinOe, interruptOut
);
  // ==========================================================
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  initial begin
    if (INT_PULSE != 8) begin
      $error("pulse length check assumes INT_PULSE of 8");
    end
  end
  // the count below is fixed at the bench value of INT_PULSE, 8
  sequence intPulse; interruptOut[*8] ##1 !interruptOut; endsequence
  sequence pinLow; !reversePowerPin[*6]; endsequence
  a_int_pulse: assert property ($rose(interruptOut) |-> intPulse)
    else $error("interrupt pulse length wrong");
  a_boost_pin: assert property (pinLow |-> !boostRun)
    else $error("boost runs with pin low");
  a_boost_lowbat: assert property ((batAboveLowBattery == 2'b00)[*6] |-> !boostRun)
    else $error("boost runs on low battery");
  a_one_mode: assert property (!(boostRun && chargeRun))
    else $error("boost and charge together");
  a_charge_pin: assert property (chargeEnableN[*6] |-> !chargeRun)
    else $error("charging while enable pin high");
  a_supplement_on: assert property (sysBelowBat[*6] |-> batterySwitchOn)
    else $error("battery switch off in supplement");
  a_dpm_reduce: assert property ((inCurOverLimit || inVoltUnderLimit)[*6] |-> reduceChargeCur)
    else $error("charge current not reduced");
  a_stat_low: assert property (chargeRun[*3] |-> statusPinOe)
    else $error("status pin not low while charging");
  a_boost_fault: assert property (boostRun && (boostOverVolt || boostOverCur) |-> ##[1:8] interruptOut)
    else $error("no interrupt on boost fault");
endmodule
bind charger_state_control charger_state_control_chk #(.INT_PULSE(INT_PULSE)) i_charger_state_control_chk (.*);

/* File: tb/host_axi.sv */
// host processor model, axi4-lite master
`timescale 1ns/1ns
module host_axi (
  // clock
  input wire logic clk_sys,
  // requests
  output logic [5:0] awaddr, araddr,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic awvalid, wvalid, bready, arvalid, rready,
  // answers
  input wire logic awready, wready, bvalid, arready, rvalid,
  input wire logic [1:0] bresp, rresp,
  input wire logic [31:0] rdata
);
  initial {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
  // each channel drops valid only at its own handshake edge
  task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge clk_sys);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, 4'hF, 3'b111};
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk_sys);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    {v, r} = {rdata, rresp};
    rready <= 0;
  endtask
endmodule

/* File: tb/charger_state_control_test.sv */
// self-checking bench of the charger control block
`timescale 1ns/1ns
module charger_state_control_test;
  import charger_pkg::*;
  logic clk_sys = 0;
  logic reset = 1;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, seed = 34;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic reversePowerPin = 0, chargeEnableN = 0, vbusBelowSleep = 0, batAbove2V = 0, batAbove3V = 0;
  logic chargeBelowTerm = 0, inCurOverLimit = 0, inVoltUnderLimit = 0, sysBelowBat = 0, sysAtMinimum = 0;
  logic thermalReg = 0, converterRunning = 0, boostOverVolt = 0, boostOverCur = 0;
  logic [1:0] batAboveLowBattery = 0, batBelowRecharge = 0, thermColdA = 0, thermHotB = 0, thermCutoff = 0;
  logic boostRun, boostCurHigh, chargeRun, fixedLowCurrent, reduceChargeCur, batterySwitchOn;
  logic statusPinOut, statusPinOe, interruptOut;
  logic [5:0] chargeCurCode;
  logic [2:0] sysMinCode, inCurLimitCode;
  logic [3:0] inVoltLimitCode;
  logic [7:0] batRegTarget;
  int nErrors = 0, testsRun = 0, cyc = 0;
  always #5 clk_sys = ~clk_sys;
  // short counts keep the run small
  charger_state_control #(.INT_PULSE(8), .BOOST_DELAY(20), .BLINK_HALF(4), .SECOND(4), .SAFETY_LIMIT(1000))
    i_charger_state_control (.*);
  host_axi i_host_axi (.*);
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [31:0] expReg(input int i, input logic [7:0] v);
    return {24'h0, (v & REG_WMASK[i]) | (REG_RST[i] & ~REG_WMASK[i])};
  endfunction
  task automatic completeRun;
    if (nErrors == 0 && testsRun > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input int i, input logic [31:0] m, input logic [31:0] e);
    i_host_axi.rd(6'(i * 4), d, r);
    check(d & m, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      nErrors++;
      completeRun();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    step(8);
    reset <= 0;
    for (int i = 0; i < 8; i++) rc(i, 32'hFF, {24'h0, REG_RST[i]});
    check(32'(inCurLimitCode), 32'(REG_RST[0][IIN_LSB +: 3]));
    check(32'(inVoltLimitCode), 32'(REG_RST[0][VIN_LSB +: 4]));
    check(32'(batRegTarget), 32'(REG_RST[4][VREG_LSB +: 6]));
    check(32'(boostCurHigh), 32'(REG_RST[1][BOOST_LIM_BIT]));
    i_host_axi.rd(6'h28, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      i_host_axi.wr(6'h08, seed, r);
      check(32'(r), 32'(RESP_OKAY));
      rc(2, 32'hFF, expReg(2, seed[7:0]));
    end
    converterRunning <= 1;
    step(6);
    check(32'(fixedLowCurrent), 1);
    batAbove2V <= 1;
    step(6);
    rc(8, 32'h30, {26'h0, PH_PRE, 4'h0});
    check(32'(statusPinOe), 1);
    check(32'(statusPinOut), 0);
    check(32'(chargeRun), 1);
    check(32'(fixedLowCurrent), 0);
    check(32'(chargeCurCode), 32'(REG_RST[3][PRE_LSB +: 4]));
    batAbove3V <= 1;
    inCurOverLimit <= 1;
    chargeBelowTerm <= 1;
    step(10);
    rc(8, 32'h38, {26'h0, PH_FAST, 4'h8});
    check(32'(reduceChargeCur), 1);
    check(32'(chargeCurCode), 32'(seed[7:2]));
    inCurOverLimit <= 0;
    for (int w = 0; w < 20 && interruptOut !== 1'b1; w++) step(1);
    check(32'(interruptOut), 1);
    rc(8, 32'h30, {26'h0, PH_DONE, 4'h0});
    check(32'(statusPinOe), 0);
    chargeBelowTerm <= 0;
    batBelowRecharge <= 2'b11;
    step(6);
    rc(8, 32'h30, {26'h0, PH_FAST, 4'h0});
    batBelowRecharge <= 0;
    thermColdA <= 2'b01;
    step(6);
    rc(9, 32'hFF, 32'h05);
    d[0] = statusPinOe;
    step(4);
    check(32'(statusPinOe), 32'(!d[0]));
    thermColdA <= 0;
    sysBelowBat <= 1;
    sysAtMinimum <= 1;
    step(6);
    check(32'(batterySwitchOn), 1);
    rc(8, 32'h01, 32'h01);
    i_host_axi.wr(6'h04, 32'h2A, r);
    {batAboveLowBattery, vbusBelowSleep, reversePowerPin} <= 4'hF;
    step(10);
    check(32'(boostRun), 0);
    check(32'(boostCurHigh), 0);
    check(32'(sysMinCode), 32'h5);
    check(32'(chargeRun), 0);
    step(30);
    check(32'(boostRun), 1);
    rc(8, 32'hC0, 32'hC0);
    i_host_axi.wr(6'h04, 32'h2B, r);
    step(6);
    check(32'(boostCurHigh), 1);
    i_host_axi.wr(6'h18, 32'hE8, r);
    step(3);
    check(32'(batRegTarget), 32'(REG_RST[4][VREG_LSB +: 6]) + 2);
    boostOverVolt <= 1;
    step(6);
    rc(9, 32'h40, 32'h40);
    check(32'(batterySwitchOn), 1);
    sysBelowBat <= 0;
    chargeEnableN <= 1;
    step(8);
    check(32'(batterySwitchOn), 0);
    completeRun();
  end
endmodule
